/* logic/rsc_pkg.sv */
package rsc_pkg;
  // clock and carrier hold time
  localparam int CLK_PERIOD_NS = 40;
  localparam int CARRIER_HOLD_NS = 50000;
  localparam int HOLD_W = 11;
  // least time: round up to whole cycles, never below one
  localparam int HOLD_CYC_INT = (CARRIER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'((HOLD_CYC_INT < 1) ? 1 : HOLD_CYC_INT);
  localparam logic [HOLD_W-1:0] HOLD_ONE = 11'h001;

  // register offsets on the serial port
  localparam logic [5:0] ADDR_RESULT = 6'h22;
  localparam logic [5:0] ADDR_CARRIER = 6'h2f;
  localparam logic [5:0] ADDR_ONE = 6'h01;

  // field positions
  localparam int RES_MSB = 4;
  localparam int RES_VALID = 5;
  localparam int FORCE_BIT = 7;
  localparam int CMD_DIR = 7;
  localparam int CMD_INC = 6;

  // reset values
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] CARRIER_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // serial framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [2:0] SYNC_RST = 3'h4;

  // measurement sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_CONV = 4'h4,
    ST_HALT = 4'h8
  } rsc_state_t;
endpackage : rsc_pkg

/* logic/rsc_bus_if.sv */
`timescale 1ns/1ps
interface rsc_bus_if;
  logic wr_stb;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : rsc_bus_if

/* logic/rsc_spi_slave.sv */
`timescale 1ns/1ps
module rsc_spi_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  output logic miso_oe_n,
  rsc_bus_if.slave bus
);
  logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic sck_prev_reg;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next, wdata_reg, wdata_next;
  logic cmd_reg, cmd_next, dir_reg, dir_next, inc_reg, inc_next;
  logic wr_reg, wr_next, bump_reg, bump_next;
  logic [5:0] addr_reg, addr_next;
  logic [7:0] byte_in;
  logic sel, rise, fall;

  // pin filter: a level counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      assign filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : filt_reg[gi];
    end
  endgenerate

  // bit 2 select, bit 1 clock, bit 0 data
  assign sel = ~filt_reg[2];
  assign rise = sel & filt_reg[1] & ~sck_prev_reg;
  assign fall = sel & ~filt_reg[1] & sck_prev_reg;
  assign byte_in = {sh_reg[6:0], filt_reg[0]};

  // framing: command byte, then data bytes with optional address step
  always_comb begin
    bit_next = bit_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    cmd_next = cmd_reg;
    dir_next = dir_reg;
    inc_next = inc_reg;
    addr_next = bump_reg ? addr_reg + rsc_pkg::ADDR_ONE : addr_reg;
    wdata_next = wdata_reg;
    wr_next = 1'b0;
    bump_next = 1'b0;
    if (!sel) begin
      bit_next = 3'h0;
      cmd_next = 1'b0;
      tx_next = rsc_pkg::BYTE_ZERO;
    end else if (rise) begin
      sh_next = byte_in;
      bit_next = bit_reg + rsc_pkg::BIT_ONE;
      if (bit_reg == rsc_pkg::BIT_LAST) begin
        if (!cmd_reg) begin
          cmd_next = 1'b1;
          dir_next = byte_in[rsc_pkg::CMD_DIR];
          inc_next = byte_in[rsc_pkg::CMD_INC];
          addr_next = byte_in[5:0];
        end else begin
          wr_next = dir_reg;
          wdata_next = byte_in;
          bump_next = inc_reg;
        end
      end
    end else if (fall) begin
      // a read byte is loaded at the first falling edge of its slot
      if (cmd_reg && !dir_reg && bit_reg == 3'h0) begin
        tx_next = bus.rdata;
      end else begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= rsc_pkg::SYNC_RST;
      s2_reg <= rsc_pkg::SYNC_RST;
      s3_reg <= rsc_pkg::SYNC_RST;
      filt_reg <= rsc_pkg::SYNC_RST;
      sck_prev_reg <= 1'b0;
      bit_reg <= 3'h0;
      sh_reg <= rsc_pkg::BYTE_ZERO;
      tx_reg <= rsc_pkg::BYTE_ZERO;
      cmd_reg <= 1'b0;
      dir_reg <= 1'b0;
      inc_reg <= 1'b0;
      addr_reg <= 6'h00;
      wdata_reg <= rsc_pkg::BYTE_ZERO;
      wr_reg <= 1'b0;
      bump_reg <= 1'b0;
    end else begin
      s1_reg <= {ss_n, sck, mosi};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      sck_prev_reg <= filt_reg[1];
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      cmd_reg <= cmd_next;
      dir_reg <= dir_next;
      inc_reg <= inc_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      bump_reg <= bump_next;
    end
  end

  // outputs toward the register file and the pin
  assign bus.wr_stb = wr_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign miso = tx_reg[7];
  assign miso_oe_n = filt_reg[2];
endmodule : rsc_spi_slave

/* logic/rsc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) convert after carrier held over 50 us
// (R2) result in bits 4:0, valid bit 5
// (R3) halt after conversion until receive re-enabled
// (R4) force bit 7 at 0x2f starts conversion
// (R5) host forces detect, waits, reads again
// (R6) host clears force bit, then disables receive
// (R7) host averages about twenty quiet readings
// (R8) host: 0-10 quiet, over 28 strong
// (R9) receive off clears valid and re-arms
module rsc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic SS_N,
  output logic MISO,
  output logic MISO_OE_N,
  input wire logic RX_MODE,
  input wire logic CARRIER_ON,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [4:0] ADC_RESULT
);
  rsc_bus_if bus ();

  rsc_pkg::rsc_state_t state_reg, state_next;
  logic [rsc_pkg::HOLD_W-1:0] hold_reg, hold_next;
  logic start_reg, start_next;
  logic [7:0] result_reg, result_next;
  logic [7:0] carrier_reg, carrier_next;
  logic carrier_eff;

  // register read decode
  function automatic logic [7:0] read_word(input logic [5:0] a,
                                           input logic [7:0] res,
                                           input logic [7:0] car);
    logic [7:0] d;
    d = rsc_pkg::BYTE_ZERO;
    case (a)
      rsc_pkg::ADDR_RESULT: d = res;
      rsc_pkg::ADDR_CARRIER: d = car;
      default: d = rsc_pkg::BYTE_ZERO;
    endcase
    return d;
  endfunction : read_word

  rsc_spi_slave u_spi (
    .clk(CLK),
    .rst(RST),
    .sck(SCK),
    .mosi(MOSI),
    .ss_n(SS_N),
    .miso(MISO),
    .miso_oe_n(MISO_OE_N),
    .bus(bus.slave)
  );

  // read data follows the addressed register
  assign bus.rdata = read_word(bus.addr, result_reg, carrier_reg);

  // force bit acts as a detected carrier
  assign carrier_eff = CARRIER_ON | carrier_reg[rsc_pkg::FORCE_BIT]; // R4

  // software register: only the force bit is stored, the result is read-only
  always_comb begin
    carrier_next = carrier_reg;
    if (bus.wr_stb && bus.addr == rsc_pkg::ADDR_CARRIER) begin
      carrier_next = rsc_pkg::CARRIER_RST;
      carrier_next[rsc_pkg::FORCE_BIT] = bus.wdata[rsc_pkg::FORCE_BIT]; // R4
    end
  end

  // force register storage
  always_ff @(posedge CLK) begin
    if (RST) begin
      carrier_reg <= rsc_pkg::CARRIER_RST;
    end else begin
      carrier_reg <= carrier_next;
    end
  end

  // measurement sequencer
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    start_next = 1'b0;
    result_next = result_reg;
    if (!RX_MODE) begin
      state_next = rsc_rsc_idle();
      hold_next = '0;
      result_next[rsc_pkg::RES_VALID] = 1'b0; // R9
    end else begin
      case (state_reg)
        rsc_pkg::ST_IDLE: begin
          hold_next = '0;
          state_next = rsc_pkg::ST_WAIT; // R9
        end
        rsc_pkg::ST_WAIT: begin
          if (!carrier_eff) begin
            hold_next = '0;
          end else if (hold_reg == rsc_pkg::HOLD_CYC) begin
            state_next = rsc_pkg::ST_CONV; // R1
            start_next = 1'b1;
          end else begin
            hold_next = hold_reg + rsc_pkg::HOLD_ONE; // R1
          end
        end
        rsc_pkg::ST_CONV: begin
          if (ADC_DONE) begin
            result_next = rsc_pkg::RESULT_RST;
            result_next[rsc_pkg::RES_MSB:0] = ADC_RESULT; // R2
            result_next[rsc_pkg::RES_VALID] = 1'b1; // R2
            state_next = rsc_pkg::ST_HALT;
          end
        end
        rsc_pkg::ST_HALT: begin
          state_next = rsc_pkg::ST_HALT; // R3
        end
        default: begin
          state_next = rsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // sequencer, hold counter, start pulse and result registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= rsc_pkg::ST_IDLE;
      hold_reg <= '0;
      start_reg <= 1'b0;
      result_reg <= rsc_pkg::RESULT_RST;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      start_reg <= start_next;
      result_reg <= result_next;
    end
  end

  // registered one-cycle start toward the converter
  assign ADC_START = start_reg;

  // idle state value, kept as a function so the decode stays in one place
  function automatic rsc_pkg::rsc_state_t rsc_rsc_idle();
    return rsc_pkg::ST_IDLE;
  endfunction : rsc_rsc_idle

  // checking helper: consecutive waiting cycles with a carrier present
  logic [rsc_pkg::HOLD_W-1:0] run_reg, run_next;

  always_comb begin
    run_next = '0;
    if (RX_MODE && state_reg == rsc_pkg::ST_WAIT && carrier_eff) begin
      run_next = (run_reg == rsc_pkg::HOLD_CYC) ? run_reg : run_reg + rsc_pkg::HOLD_ONE;
    end
  end

  // helper run counter storage
  always_ff @(posedge CLK) begin
    if (RST) begin
      run_reg <= '0;
    end else begin
      run_reg <= run_next;
    end
  end

  // rule checks, all on the system clock and quiet during reset
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_start_after_hold: assert property ( // R1
    ADC_START |-> $past(run_reg) == rsc_pkg::HOLD_CYC && $past(carrier_eff)
  ) else $error("conversion started before carrier hold time");

  a_result_capture: assert property ( // R2
    (state_reg == rsc_pkg::ST_CONV && RX_MODE && ADC_DONE) |=>
      result_reg[rsc_pkg::RES_MSB:0] == $past(ADC_RESULT) &&
      result_reg[rsc_pkg::RES_VALID] && result_reg[7:6] == 2'h0
  ) else $error("conversion result or valid flag not stored");

  a_halt_holds: assert property ( // R3
    (state_reg == rsc_pkg::ST_HALT && RX_MODE) |=>
      state_reg == rsc_pkg::ST_HALT && !ADC_START
  ) else $error("sequencer left halt while receive stayed on");

  a_force_starts: assert property ( // R4
    (carrier_reg[rsc_pkg::FORCE_BIT] && RX_MODE && state_reg == rsc_pkg::ST_WAIT &&
     hold_reg == rsc_pkg::HOLD_CYC) |=> ADC_START && state_reg == rsc_pkg::ST_CONV
  ) else $error("forced carrier did not start a conversion");

  a_rx_off_rearm: assert property ( // R9
    !RX_MODE |=> state_reg == rsc_pkg::ST_IDLE && !result_reg[rsc_pkg::RES_VALID]
  ) else $error("receive off did not clear valid and re-arm");

  a_start_single: assert property ( // R1
    ADC_START |=> !ADC_START
  ) else $error("conversion start longer than one cycle");

  a_no_carrier_wait: assert property ( // R1
    (RX_MODE && state_reg == rsc_pkg::ST_WAIT && !carrier_eff) |=> !ADC_START
  ) else $error("conversion started without a carrier");

  a_force_stored: assert property ( // R4
    (bus.wr_stb && bus.addr == rsc_pkg::ADDR_CARRIER) |=>
      carrier_reg[rsc_pkg::FORCE_BIT] == $past(bus.wdata[rsc_pkg::FORCE_BIT]) &&
      carrier_reg[6:0] == 7'h00
  ) else $error("carrier register write not stored as force bit only");

  a_done_ignored: assert property ( // R3
    (ADC_DONE && state_reg != rsc_pkg::ST_CONV) |=>
      result_reg[rsc_pkg::RES_MSB:0] == $past(result_reg[rsc_pkg::RES_MSB:0])
  ) else $error("result changed by a done outside conversion");

  // main scenarios
  c_conversion_start: cover property (ADC_START);
  c_result_valid: cover property (state_reg == rsc_pkg::ST_CONV && ADC_DONE && RX_MODE);
  c_rearm_after_halt: cover property (state_reg == rsc_pkg::ST_HALT ##1 !RX_MODE);
  c_force_written: cover property (bus.wr_stb && bus.addr == rsc_pkg::ADDR_CARRIER);
  c_forced_start: cover property (ADC_START && carrier_reg[rsc_pkg::FORCE_BIT]);
endmodule : rsc_top

/* testbench/rsc_host.sv */
`timescale 1ns/1ps
// host stand-in: mode 0 serial master plus receive enable
module rsc_host (
  input wire logic CLK,
  output logic SCK,
  output logic MOSI,
  output logic SS_N,
  output logic RX_MODE,
  input wire logic MISO
);
  initial begin
    SCK = 1'b0;
    MOSI = 1'b0;
    SS_N = 1'b1;
    RX_MODE = 1'b0;
  end
  // one serial clock phase, six system clocks
  task automatic half();
    repeat (6) @(posedge CLK);
  endtask : half
  // command byte then one data byte, miso sampled on rises
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] din, output logic [7:0] dout);
    logic [15:0] sh;
    sh = {cmd, din};
    dout = 8'h00;
    @(posedge CLK);
    SS_N <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      half();
      MOSI <= sh[i];
      half();
      SCK <= 1'b1;
      if (i < 8) dout[i] = MISO;
      half();
      SCK <= 1'b0;
    end
    half();
    SS_N <= 1'b1;
    MOSI <= ~MOSI; // released line does not keep its value
    half();
  endtask : xfer
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({2'b10, a}, d, x);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    xfer({2'b00, a}, 8'h00, d);
  endtask : rd
  task automatic rx(input logic v);
    @(posedge CLK);
    RX_MODE <= v;
  endtask : rx
  // quiet-channel measurement with forced carrier
  task automatic quiet(output logic [7:0] r0, output logic [7:0] r1);
    rx(1'b1);
    rd(6'h22, r0);
    if (r0[5] == 1'b0) begin
      wr(6'h2f, 8'h80);
      repeat (1300) @(posedge CLK);
    end
    rd(6'h22, r1);
    wr(6'h2f, 8'h00);
    rx(1'b0);
  endtask : quiet
endmodule : rsc_host

/* testbench/test_signal_strength_result_conversion_control.sv */
`timescale 1ns/1ps
// self-checking bench for the signal-strength sequencer
module test_signal_strength_result_conversion_control;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CARRIER_ON = 1'b0;
  logic ADC_DONE = 1'b0;
  logic [4:0] ADC_RESULT = 5'h00;
  logic SCK, MOSI, SS_N, MISO, MISO_OE_N, RX_MODE, ADC_START;
  logic stray = 1'b0;
  logic [31:0] lfsr = 32'h55d356f3;
  logic [7:0] r0, r1;
  int error_cnt = 0;
  int tests_run = 0;
  int starts = 0;
  int mdl_val = 0;
  int q[$];
  int n, sum;

  always #20 CLK = ~CLK;

  rsc_top i_rsc_top (.CLK(CLK), .RST(RST), .SCK(SCK), .MOSI(MOSI), .SS_N(SS_N),
    .MISO(MISO), .MISO_OE_N(MISO_OE_N), .RX_MODE(RX_MODE), .CARRIER_ON(CARRIER_ON),
    .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT));
  rsc_host i_rsc_host (.CLK(CLK), .SCK(SCK), .MOSI(MOSI), .SS_N(SS_N),
    .RX_MODE(RX_MODE), .MISO(MISO));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  // adc stand-in: answers a start next edge with a random value
  always @(posedge CLK) begin
    lfsr <= step(lfsr);
    ADC_DONE <= ADC_START | stray;
    ADC_RESULT <= lfsr[4:0];
    if (ADC_START === 1'b1) begin
      starts <= starts + 1;
      mdl_val <= int'(lfsr[4:0]);
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // watchdog against a hung sequence
  initial begin
    repeat (80000) @(posedge CLK);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    chk("oe_idle", {7'h00, MISO_OE_N}, 8'h01);
    i_rsc_host.rd(6'h22, r0);
    chk("res_rst", r0, 8'h00);
    i_rsc_host.rd(6'h2f, r0);
    chk("car_rst", r0, 8'h00);
    i_rsc_host.wr(6'h22, 8'hff);
    i_rsc_host.rd(6'h22, r0);
    chk("res_ro", r0, 8'h00);
    i_rsc_host.rd(6'h10, r0);
    chk("unmapped", r0, 8'h00);
    // carrier with one dropout: hold count restarts
    i_rsc_host.rx(1'b1);
    CARRIER_ON <= 1'b1;
    repeat (800) @(posedge CLK);
    CARRIER_ON <= 1'b0;
    @(posedge CLK);
    CARRIER_ON <= 1'b1;
    n = 0;
    while (ADC_START !== 1'b1 && n < 1400) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk("hold_win", 8'(n >= 1251 && n <= 1254), 8'h01);
    @(posedge CLK);
    #1;
    chk("start_pulse", {7'h00, ADC_START}, 8'h00);
    // stray done while halted must be ignored
    @(posedge CLK);
    stray <= 1'b1;
    @(posedge CLK);
    stray <= 1'b0;
    i_rsc_host.rd(6'h22, r0);
    chk("result", r0, 8'(mdl_val) | 8'h20);
    i_rsc_host.wr(6'h2f, 8'hff);
    i_rsc_host.rd(6'h2f, r0);
    chk("force_rd", r0, 8'h80);
    repeat (1400) @(posedge CLK);
    chk("halt_starts", 8'(starts), 8'h01);
    i_rsc_host.rd(6'h22, r0);
    chk("halt_res", r0, 8'(mdl_val) | 8'h20);
    i_rsc_host.wr(6'h2f, 8'h00);
    CARRIER_ON <= 1'b0;
    i_rsc_host.rx(1'b0);
    i_rsc_host.rd(6'h22, r0);
    chk("rx_off", r0, 8'(mdl_val));
    // repeated forced quiet-channel measurements
    for (int k = 0; k < 20; k++) begin
      n = mdl_val;
      i_rsc_host.quiet(r0, r1);
      chk("rearm", r0, 8'(n));
      chk("forced", r1, 8'(mdl_val) | 8'h20);
      q.push_back(int'(r1[4:0]));
    end
    chk("starts", 8'(starts), 8'h15);
    sum = 0;
    foreach (q[i]) sum += q[i];
    sum = sum / q.size();
    $display("floor %0d quiet %0d strong %0d", sum, sum <= 10, sum > 28);
    print_verdict();
  end
endmodule : test_signal_strength_result_conversion_control
